// ==== logger_pkg.sv ====
// shared constants, types and carriers of the reading record logger
package logger_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned SECOND_NS     = 1000000000;
   localparam int unsigned TICK_CYCLES   = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [11:0] PERIOD_MIN_S  = 12'h001;
   localparam logic [11:0] PERIOD_MAX_S  = 12'he10;
   localparam logic [11:0] PRINT_MIN_S   = 12'h00a;

   // ---------------------------------------------------------------
   // record store geometry
   // ---------------------------------------------------------------
   localparam int unsigned REGION_BYTES = 12288;
   localparam int unsigned MAX_SLOTS    = 8;
   localparam int unsigned NUM_INPUTS   = 8;
   localparam int unsigned NUM_SOURCES  = 4;
   localparam int unsigned READ_W       = 16;
   localparam int unsigned IDX_W        = 11;
   // records held for 1..8 readings: 1500 1000 750 600 500 425 375 340
   localparam logic [10:0] REC_CAP [MAX_SLOTS] = '{
      11'h5dc, 11'h3e8, 11'h2ee, 11'h258, 11'h1f4, 11'h1a9, 11'h177, 11'h154};

   // ---------------------------------------------------------------
   // time stamp limits and reset values
   // ---------------------------------------------------------------
   localparam logic [6:0] HOUR_MAX  = 7'h18;
   localparam logic [6:0] MINSEC_MAX = 7'h3c;
   localparam logic [6:0] MONTH_MAX = 7'h0c;
   localparam logic [6:0] DAY_MAX   = 7'h1f;
   localparam logic [6:0] YEAR_MAX  = 7'h63;
   localparam logic [6:0] FIELD_FIRST = 7'h01;
   localparam logic [6:0] YEAR_FIRST  = 7'h00;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      mode_off, mode_log_cont, mode_log_event, mode_print_cont, mode_print_event
   } mode_t;

   typedef enum logic [1:0] {
      src_kelvin, src_celsius, src_sensor, src_linear
   } source_t;

   typedef struct packed {
      mode_t                     mode;
      logic                      overwrite;
      logic                      start_clear;
      logic [11:0]               period_s;
      logic [3:0]                nread;
      logic [MAX_SLOTS-1:0][2:0] slot_input;
      source_t [MAX_SLOTS-1:0]   slot_src;
   } setup_t;

   typedef struct packed {
      logic [NUM_INPUTS-1:0][NUM_SOURCES-1:0][READ_W-1:0] value;
      logic [NUM_INPUTS-1:0]                              alarm;
      logic [NUM_INPUTS-1:0]                              fault;
   } sensor_bus_t;

   typedef struct packed {
      logic [6:0] month;
      logic [6:0] day;
      logic [6:0] year;
      logic [6:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
   } stamp_t;

   typedef struct packed {
      logic                             to_printer;
      logic [IDX_W-1:0]                 index;
      stamp_t                           stamp;
      logic [3:0]                       nread;
      logic [MAX_SLOTS-1:0][READ_W-1:0] reading;
   } log_record_t;

endpackage

// ==== record_buffer.sv ====
// two-entry valid/ready buffer for record words
`timescale 1ns/1ps

module record_buffer #(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   typedef struct packed {
      logic             v0;
      logic             v1;
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
   } buf_state_t;

   buf_state_t s_reg;
   buf_state_t s_next;

   always_comb
   begin
      s_next = s_reg;
      if (s_reg.v0 && out_ready)
      begin
         s_next.d0 = s_reg.d1;
         s_next.v0 = s_reg.v1;
         s_next.v1 = 1'b0;
      end
      // accept only on the registered free flag so in_ready stays a flop
      if (in_valid && !s_reg.v1)
      begin
         if (!s_next.v0)
         begin
            s_next.d0 = in_data;
            s_next.v0 = 1'b1;
         end
         else
         begin
            s_next.d1 = in_data;
            s_next.v1 = 1'b1;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign in_ready  = !s_reg.v1;
   assign out_valid = s_reg.v0;
   assign out_data  = s_reg.d0;

endmodule // record_buffer

// ==== record_logger.sv ====
// reading record logger: capture sequencing, time stamp and record routing
`timescale 1ns/1ps

// Behaviour
// - a record holds one to eight readings plus time stamp, any input and source
// - records live in a dedicated twelve kilobyte store region
// - capacity per readings count: 1500,1000,750,600,500,425,375,340
// - any setup change erases all stored records
// - disabled mode: toggle does not start, running capture stops
// - continuous store: one record to memory each period
// - event store: record only when a selected input alarm/error changes
// - continuous print: records to printer, at least ten seconds apart
// - event print: event records go to printer, not memory
// - overwrite on: keep capturing past capacity, replacing oldest
// - overwrite off: stop capture at the maximum record count
// - start clear: start empties the store before the first record
// - start continue: start appends after existing records
// - print modes: effective period never below ten seconds
// - each slot takes kelvin, celsius, sensor units or linear result
// - storage and printing never both active
// - one toggle alternately starts and stops capture per policies
// - active indicator on while capturing, off when halted at full store
// - records and clock survive power loss, capture resumes on return
module record_logger #(
   parameter int unsigned TICK_CYCLES = logger_pkg::TICK_CYCLES
) (
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logger_pkg::setup_t       setup,
   input  wire logger_pkg::sensor_bus_t  sensors,
   input  wire logic                     toggle_pin,
   input  wire logic                     power_ok_pin,
   input  wire logic                     time_load,
   input  wire logger_pkg::stamp_t       time_value,
   output logic                          rec_valid,
   input  wire logic                     rec_ready,
   output logger_pkg::log_record_t       rec,
   output logic                          active,
   output logic [logger_pkg::IDX_W-1:0]  record_count
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   localparam int unsigned TW = $clog2(TICK_CYCLES);

   typedef enum logic [1:0] {st_idle, st_run, st_full} run_t;

   typedef struct packed {
      run_t                        st;
      logic                        active;
      logic [TW-1:0]               tick_cnt;
      logic [11:0]                 sec_cnt;
      logger_pkg::stamp_t          stamp;
      logic [logger_pkg::IDX_W-1:0] count;
      logic [logger_pkg::IDX_W-1:0] wr_idx;
      logger_pkg::setup_t          setup_prev;
      logic                        setup_seen;
      logic [7:0]                  alarm_prev;
      logic [7:0]                  fault_prev;
      logic [2:0]                  tog_sync;
      logic                        tog_lvl;
      logic [2:0]                  pwr_sync;
      logic                        pwr_lvl;
      logic                        pend;
      logger_pkg::log_record_t     rec;
   } log_state_t;

   log_state_t s_reg;
   log_state_t s_next;

   logic                         push_ready;
   logic                         tick;
   logic                         press;
   logic                         print_mode;
   logic                         event_mode;
   logic [11:0]                  eff_period;
   logic [logger_pkg::IDX_W-1:0] cap;
   logic [7:0]                   in_mask;
   logic                         changed;
   logic                         request;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      s_next     = s_reg;
      in_mask    = '0;
      request    = 1'b0;
      tick       = (s_reg.tick_cnt == TW'(TICK_CYCLES - 1));
      print_mode = (setup.mode == logger_pkg::mode_print_cont)
                || (setup.mode == logger_pkg::mode_print_event);
      event_mode = (setup.mode == logger_pkg::mode_log_event)
                || (setup.mode == logger_pkg::mode_print_event);
      cap        = logger_pkg::REC_CAP[3'(setup.nread - 4'h1)];

      // printer needs breathing room between records
      if (print_mode && (setup.period_s < logger_pkg::PRINT_MIN_S))
         eff_period = logger_pkg::PRINT_MIN_S;
      else
         eff_period = setup.period_s;

      // one-second enable
      s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + TW'(1);

      // pin inputs: a change counts once the last two stages agree
      s_next.tog_sync = {s_reg.tog_sync[1:0], toggle_pin};
      s_next.pwr_sync = {s_reg.pwr_sync[1:0], power_ok_pin};
      if (s_reg.tog_sync[2] == s_reg.tog_sync[1])
         s_next.tog_lvl = s_reg.tog_sync[2];
      if (s_reg.pwr_sync[2] == s_reg.pwr_sync[1])
         s_next.pwr_lvl = s_reg.pwr_sync[2];
      press = s_next.tog_lvl && !s_reg.tog_lvl;

      // time stamp clock; keeps running while capture is paused
      if (time_load)
         s_next.stamp = time_value;
      else if (tick)
      begin
         s_next.stamp.second = s_reg.stamp.second + 7'h01;
         if (s_reg.stamp.second == logger_pkg::MINSEC_MAX)
         begin
            s_next.stamp.second = logger_pkg::FIELD_FIRST;
            s_next.stamp.minute = s_reg.stamp.minute + 7'h01;
            if (s_reg.stamp.minute == logger_pkg::MINSEC_MAX)
            begin
               s_next.stamp.minute = logger_pkg::FIELD_FIRST;
               s_next.stamp.hour   = s_reg.stamp.hour + 7'h01;
               if (s_reg.stamp.hour == logger_pkg::HOUR_MAX)
               begin
                  s_next.stamp.hour = logger_pkg::FIELD_FIRST;
                  s_next.stamp.day  = s_reg.stamp.day + 7'h01;
                  if (s_reg.stamp.day == logger_pkg::DAY_MAX)
                  begin
                     s_next.stamp.day   = logger_pkg::FIELD_FIRST;
                     s_next.stamp.month = s_reg.stamp.month + 7'h01;
                     if (s_reg.stamp.month == logger_pkg::MONTH_MAX)
                     begin
                        s_next.stamp.month = logger_pkg::FIELD_FIRST;
                        s_next.stamp.year  = (s_reg.stamp.year == logger_pkg::YEAR_MAX)
                                           ? logger_pkg::YEAR_FIRST
                                           : s_reg.stamp.year + 7'h01;
                     end
                  end
               end
            end
         end
      end

      // inputs watched for events: those named by the used slots
      for (int i = 0; i < logger_pkg::MAX_SLOTS; i++)
      begin
         if (4'(i) < setup.nread)
            in_mask[setup.slot_input[i]] = 1'b1;
      end
      changed = |(((sensors.alarm ^ s_reg.alarm_prev)
                 | (sensors.fault ^ s_reg.fault_prev)) & in_mask);
      s_next.alarm_prev = sensors.alarm;
      s_next.fault_prev = sensors.fault;

      // buffer took the pending record
      if (s_reg.pend && push_ready)
         s_next.pend = 1'b0;

      // start/stop sequencing
      case (s_reg.st)
         st_idle, st_full:
         begin
            // a full store with overwrite off and start continue has no room left
            if (press && (setup.mode != logger_pkg::mode_off)
                && (setup.start_clear || setup.overwrite || (s_reg.count != cap)))
            begin
               s_next.st      = st_run;
               s_next.sec_cnt = '0;
               if (setup.start_clear)
               begin
                  s_next.count  = '0;
                  s_next.wr_idx = '0;
               end
               // otherwise existing records stay and new ones follow
            end
         end
         st_run:
         begin
            if (press || (setup.mode == logger_pkg::mode_off))
               s_next.st = st_idle;
            else if (s_reg.pwr_lvl)
            begin
               // capture only while power is good; the period count is held meanwhile
               if (event_mode)
                  request = changed;
               else if (tick)
               begin
                  if (s_reg.sec_cnt + 12'h001 >= eff_period)
                  begin
                     request        = 1'b1;
                     s_next.sec_cnt = '0;
                  end
                  else
                     s_next.sec_cnt = s_reg.sec_cnt + 12'h001;
               end
            end
         end
         default:
            s_next.st = st_idle;
      endcase

      // a request while the previous record still waits on the buffer is dropped;
      // a stalled receiver therefore loses records rather than slowing capture
      if (request && !(s_reg.pend && !push_ready))
      begin
         s_next.pend             = 1'b1;
         s_next.rec.to_printer   = print_mode;
         s_next.rec.stamp        = s_reg.stamp;
         s_next.rec.nread        = setup.nread;
         s_next.rec.index        = s_reg.wr_idx;
         for (int i = 0; i < logger_pkg::MAX_SLOTS; i++)
         begin
            if (4'(i) < setup.nread)
               s_next.rec.reading[i] =
                  sensors.value[setup.slot_input[i]][setup.slot_src[i]];
            else
               s_next.rec.reading[i] = '0;
         end
         if (!print_mode)
         begin
            s_next.wr_idx = (s_reg.wr_idx == cap - 11'h001) ? '0
                          : s_reg.wr_idx + 11'h001;
            if (s_reg.count != cap)
               s_next.count = s_reg.count + 11'h001;
            if (!setup.overwrite && (s_reg.count == cap - 11'h001))
               s_next.st = st_full;
         end
      end

      // the setup is taken as changed on its first sight after reset too
      if (!s_reg.setup_seen || (setup != s_reg.setup_prev))
      begin
         s_next.setup_prev = setup;
         s_next.setup_seen = 1'b1;
         s_next.count      = '0;
         s_next.wr_idx     = '0;
      end

      s_next.active = (s_next.st == st_run);
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         s_reg              <= '0;
         s_reg.st           <= st_idle;
         s_reg.stamp.month  <= logger_pkg::FIELD_FIRST;
         s_reg.stamp.day    <= logger_pkg::FIELD_FIRST;
         s_reg.stamp.hour   <= logger_pkg::FIELD_FIRST;
         s_reg.stamp.minute <= logger_pkg::FIELD_FIRST;
         s_reg.stamp.second <= logger_pkg::FIELD_FIRST;
      end
      else
         s_reg <= s_next;
   end

   // ---------------------------------------------------------------
   // record path
   // ---------------------------------------------------------------
   record_buffer #(
      .WIDTH ($bits(logger_pkg::log_record_t))
   ) u_buffer (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (s_reg.pend),
      .in_ready  (push_ready),
      .in_data   (s_reg.rec),
      .out_valid (rec_valid),
      .out_ready (rec_ready),
      .out_data  (rec)
   );

   assign active       = s_reg.active;
   assign record_count = s_reg.count;

endmodule // record_logger

// ==== record_logger_chk.sv ====
// port checker for the reading record logger, bound to its top module
`timescale 1ns/1ps

module record_logger_chk #(
   parameter int unsigned TICK_CYCLES = 10
) (
   input wire logic                               clk,
   input wire logic                               rst_n,
   input wire logger_pkg::setup_t                 setup,
   input wire logger_pkg::sensor_bus_t            sensors,
   input wire logic                               toggle_pin,
   input wire logic                               power_ok_pin,
   input wire logic                               time_load,
   input wire logger_pkg::stamp_t                 time_value,
   input wire logic                               rec_valid,
   input wire logic                               rec_ready,
   input wire logger_pkg::log_record_t            rec,
   input wire logic                               active,
   input wire logic [logger_pkg::IDX_W-1:0]       record_count
);
   logic [10:0] cap;
   logic        prn;
   // nread 8 wraps to index 7 through the three-bit slice
   assign cap = logger_pkg::REC_CAP[3'(setup.nread[2:0] - 3'h1)];
   assign prn = setup.mode inside {logger_pkg::mode_print_cont, logger_pkg::mode_print_event};

   function automatic logic tail_zero(input logger_pkg::log_record_t r);
      for (int i = 0; i < 8; i++)
         if (i >= r.nread && r.reading[i] != '0) return 1'b0;
      return 1'b1;
   endfunction

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_hold; rec_valid && !rec_ready |=> rec_valid && $stable(rec); endproperty
   a_hold: assert property (p_hold) else $error("record moved while stalled");
   property p_tail; rec_valid |-> tail_zero(rec); endproperty
   a_tail: assert property (p_tail) else $error("unused reading slot not zero");
   property p_cap; $stable(setup) |-> record_count <= cap; endproperty
   a_cap: assert property (p_cap) else $error("record count above capacity");
   property p_clear; !$stable(setup) |=> record_count == '0; endproperty
   a_clear: assert property (p_clear) else $error("setup change kept records");
   property p_off; setup.mode == logger_pkg::mode_off |=> !active; endproperty
   a_off: assert property (p_off) else $error("active while disabled");
   property p_full; active && !setup.overwrite && $stable(setup) && record_count == cap
      |-> ##[0:1] !active; endproperty
   a_full: assert property (p_full) else $error("capture ran past full store");
   property p_print; prn && $stable(setup) |=> $stable(record_count); endproperty
   a_print: assert property (p_print) else $error("print mode stored a record");
   property p_idx; rec_valid && !rec.to_printer && $stable(setup) |-> rec.index < cap; endproperty
   a_idx: assert property (p_idx) else $error("store index beyond capacity");
   property p_start; $rose(active) |-> $past(toggle_pin, 2) && setup.mode != '0; endproperty
   a_start: assert property (p_start) else $error("capture began without a press");

   c_start: cover property ($rose(active));
   c_print: cover property (rec_valid && rec_ready && rec.to_printer);
   c_full: cover property (record_count == cap && !active);
endmodule // record_logger_chk

bind record_logger record_logger_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (
   .clk(clk), .rst_n(rst_n), .setup(setup), .sensors(sensors), .toggle_pin(toggle_pin),
   .power_ok_pin(power_ok_pin), .time_load(time_load), .time_value(time_value),
   .rec_valid(rec_valid), .rec_ready(rec_ready), .rec(rec), .active(active),
   .record_count(record_count));

// ==== record_sink.sv ====
// far-side model: takes records from the logger, fast or stalling
`timescale 1ns/1ps

module record_sink (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    slow,
   input  wire logic                    rec_valid,
   input  wire logger_pkg::log_record_t rec,
   output logic                         rec_ready,
   output int                           taken,
   output int                           gap,
   output logger_pkg::log_record_t      last
);
   logic [1:0] phase_reg;
   int         now_reg;
   int         seen_reg;

   // slow mode takes one cycle in three so the two-entry buffer backs up
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         phase_reg <= 2'h0;
         now_reg <= 0;
         seen_reg <= 0;
         rec_ready <= 1'b0;
         taken <= 0;
         gap <= 0;
         last <= '0;
      end
      else
      begin
         phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
         now_reg <= now_reg + 1;
         rec_ready <= !slow || phase_reg == 2'h1;
         if (rec_valid && rec_ready)
         begin
            taken <= taken + 1;
            gap <= now_reg - seen_reg;
            seen_reg <= now_reg;
            last <= rec;
         end
      end
   end
endmodule // record_sink

// ==== testbench.sv ====
// self-checking bench for the reading record logger
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
      end \
   end

module testbench;
   localparam int TICK = 10;
   logic                    clk = 1'b0;
   logic                    rst_n;
   logic                    toggle_pin;
   logic                    power_ok_pin;
   logic                    time_load;
   logic                    slow;
   logic                    rec_valid;
   logic                    rec_ready;
   logic                    active;
   logic [10:0]             record_count;
   logic [10:0]             held;
   logger_pkg::setup_t      setup;
   logger_pkg::sensor_bus_t sensors;
   logger_pkg::stamp_t      time_value;
   logger_pkg::log_record_t rec;
   logger_pkg::log_record_t last;
   int                      taken;
   int                      gap;
   int                      base;
   int                      bad_count = 0;
   int                      num_checks = 0;

   always #20 clk = ~clk;

   record_logger #(.TICK_CYCLES(TICK)) uut (.clk(clk), .rst_n(rst_n), .setup(setup),
      .sensors(sensors), .toggle_pin(toggle_pin), .power_ok_pin(power_ok_pin),
      .time_load(time_load), .time_value(time_value), .rec_valid(rec_valid),
      .rec_ready(rec_ready), .rec(rec), .active(active), .record_count(record_count));
   record_sink sink (.clk(clk), .rst_n(rst_n), .slow(slow), .rec_valid(rec_valid),
      .rec(rec), .rec_ready(rec_ready), .taken(taken), .gap(gap), .last(last));

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   // pin held six cycles: the filter needs two and the start takes four
   task automatic press();
      idle(1);
      toggle_pin <= 1'b1;
      idle(6);
      toggle_pin <= 1'b0;
      idle(6);
   endtask

   task automatic wait_taken(input int n);
      int k;
      k = 0;
      while (taken < n && k < 6000)
      begin
         idle(1);
         k++;
      end
      `CHK(taken >= n, 1'b1)
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("unexpected at %0t: watchdog expired", $time);
      summarize();
   end

   // ---------------------------------------------------------------
   // test sequence
   // ---------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      toggle_pin = 1'b0;
      power_ok_pin = 1'b1;
      time_load = 1'b0;
      slow = 1'b0;
      time_value = '{7'h06, 7'h09, 7'h62, 7'h0f, 7'h21, 7'h1e};
      setup = '0;
      setup.start_clear = 1'b1;
      setup.period_s = 12'h001;
      setup.nread = 4'h8;
      sensors = '0;
      for (int k = 0; k < 8; k++)
      begin
         setup.slot_input[k] = 3'(7 - k);
         setup.slot_src[k] = logger_pkg::source_t'(k % 4);
         for (int s = 0; s < 4; s++)
            sensors.value[k][s] = 16'(k * 256 + s * 16 + 1);
      end
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      idle(5);
      `CHK(active, 1'b0)
      `CHK(record_count, 11'h000)
      time_load <= 1'b1;
      idle(1);
      time_load <= 1'b0;
      press();
      `CHK(active, 1'b0)
      $display("test disabled start done");
      setup.mode <= logger_pkg::mode_log_cont;
      idle(3);
      press();
      `CHK(active, 1'b1)
      wait_taken(1);
      `CHK(last.to_printer, 1'b0)
      `CHK(last.index, 11'h000)
      `CHK(last.nread, 4'h8)
      `CHK(last.stamp.month, 7'h06)
      `CHK(last.stamp.year, 7'h62)
      `CHK(last.stamp.hour, 7'h0f)
      for (int k = 0; k < 8; k++)
         `CHK(last.reading[k], sensors.value[setup.slot_input[k]][setup.slot_src[k]])
      base = 0;
      while (active && base < 5000)
      begin
         idle(1);
         base++;
      end
      idle(4);
      `CHK(active, 1'b0)
      `CHK(record_count, 11'h154)
      `CHK(taken, 340)
      `CHK(gap, TICK)
      press();
      wait_taken(341);
      `CHK(last.index, 11'h000)
      press();
      $display("test continuous store done");
      setup.start_clear <= 1'b0;
      idle(3);
      `CHK(record_count, 11'h000)
      press();
      wait_taken(taken + 3);
      press();
      idle(4);
      held = record_count;
      base = taken;
      press();
      wait_taken(base + 2);
      `CHK(last.index, held + 11'h001)
      power_ok_pin <= 1'b0;
      idle(10);
      base = taken;
      idle(60);
      `CHK(taken, base)
      `CHK(active, 1'b1)
      power_ok_pin <= 1'b1;
      wait_taken(base + 1);
      press();
      $display("test append and power done");
      setup.overwrite <= 1'b1;
      setup.start_clear <= 1'b1;
      slow <= 1'b1;
      idle(3);
      base = taken;
      press();
      wait_taken(base + 345);
      `CHK(record_count, 11'h154)
      `CHK(last.index, 11'h004)
      `CHK(active, 1'b1)
      press();
      slow <= 1'b0;
      $display("test overwrite done");
      setup.mode <= logger_pkg::mode_print_cont;
      idle(3);
      press();
      base = taken;
      wait_taken(base + 3);
      `CHK(gap >= 10 * TICK, 1'b1)
      `CHK(last.to_printer, 1'b1)
      `CHK(record_count, 11'h000)
      press();
      $display("test print continuous done");
      setup.mode <= logger_pkg::mode_log_event;
      setup.nread <= 4'h1;
      idle(3);
      press();
      idle(10);
      base = taken;
      sensors.alarm[3] <= 1'b1;
      idle(20);
      `CHK(taken, base)
      sensors.alarm[7] <= 1'b1;
      idle(20);
      `CHK(taken, base + 1)
      sensors.fault[7] <= 1'b1;
      idle(20);
      `CHK(taken, base + 2)
      `CHK(last.to_printer, 1'b0)
      setup.mode <= logger_pkg::mode_print_event;
      idle(3);
      sensors.alarm[7] <= 1'b0;
      idle(20);
      `CHK(taken, base + 3)
      `CHK(last.to_printer, 1'b1)
      // three events in a row against a stalling printer: none may be lost
      slow <= 1'b1;
      sensors.alarm[7] <= 1'b1;
      idle(1);
      sensors.fault[7] <= 1'b0;
      idle(1);
      sensors.alarm[7] <= 1'b0;
      idle(30);
      `CHK(taken, base + 6)
      `CHK(last.to_printer, 1'b1)
      slow <= 1'b0;
      setup.mode <= logger_pkg::mode_off;
      idle(3);
      `CHK(active, 1'b0)
      $display("test events done");
      summarize();
   end
endmodule // testbench
